//--- verilog/dat_translator.sv
// dat_translator: dma address translation for the network and storage masters
module dat_translator
  import dat_pkg::*;
#(
  parameter int TBL_ENTRIES = dat_pkg::DAT_TBL_ENTRY
)
(
  // clock and reset
  input  wire logic                                 CLK,
  input  wire logic                                 ARST_N,
  // map table base
  input  wire logic [dat_pkg::DAT_PHYS_W-1:0]       MAP_BASE_ADDR,
  // dma masters, index 0 network, 1 storage
  input  dat_pkg::dat_dma_req_s [dat_pkg::DAT_MASTERS-1:0] DMA_REQ,
  output logic [dat_pkg::DAT_MASTERS-1:0]           DMA_DONE,
  output logic [dat_pkg::DAT_PHYS_W-1:0]            DMA_PADDR,
  // memory arbiter side
  output dat_pkg::dat_mem_req_s                     MEM_REQ,
  input  dat_pkg::dat_mem_rsp_s                     MEM_RSP
);
  import dat_pkg::*;

  if (TBL_ENTRIES != (1 << DAT_PAGE_W))
  begin : g_bad_size
    $error("table size must equal the page space");
  end

  typedef struct packed {
    dat_state_e                   st;
    logic                         cur;
    logic                         wr;
    logic [DAT_ADDR_W-1:0]        addr;
    logic [DAT_MASTERS-1:0]       done;
    logic [DAT_PHYS_W-1:0]        paddr;
    dat_mem_req_s                 mem;
    logic                         fill;
    logic [DAT_PPAGE_W-1:0]       fill_ppage;
  } dat_top_s;

  dat_top_s                  state_reg;
  dat_top_s                  state_next;
  logic [DAT_MASTERS-1:0]    hit_m;
  logic [DAT_PPAGE_W-1:0]    ppage_m [DAT_MASTERS];
  logic [DAT_MASTERS-1:0]    want;
  logic [DAT_PAGE_W-1:0]     cur_page;
  logic [DAT_OFS_W-1:0]      cur_ofs;
  logic [DAT_MAP_ADDR_W-1:0] map_addr;

  assign cur_page = state_reg.addr[DAT_ADDR_W-1:DAT_OFS_W];
  assign cur_ofs  = state_reg.addr[DAT_OFS_W-1:0];
  assign map_addr = {MAP_BASE_ADDR[DAT_BASE_HI:DAT_BASE_LO], cur_page};

  generate
    for (genvar m = 0; m < DAT_MASTERS; m++)
    begin : g_cache
      assign want[m] = DMA_REQ[m].valid && !state_reg.done[m];
      dat_cache u_cache (
        .clk        (CLK),
        .arst_n     (ARST_N),
        .lk_write   (state_reg.wr),
        .lk_page    (cur_page),
        .hit        (hit_m[m]),
        .hit_ppage  (ppage_m[m]),
        .fill       (state_reg.fill && (state_reg.cur == 1'(m))),
        .fill_write (state_reg.wr),
        .fill_page  (cur_page),
        .fill_ppage (state_reg.fill_ppage)
      );
    end
  endgenerate

  always_comb
  begin
    state_next      = state_reg;
    state_next.done = '0;
    state_next.fill = 1'b0;
    case (state_reg.st)
      DAT_IDLE:
      begin
        if (want[DAT_NET])
        begin
          state_next.cur  = 1'b0;
          state_next.wr   = DMA_REQ[DAT_NET].write;
          state_next.addr = DMA_REQ[DAT_NET].addr;
          state_next.st   = DAT_LOOKUP;
        end
        else if (want[DAT_STO])
        begin
          state_next.cur  = 1'b1;
          state_next.wr   = DMA_REQ[DAT_STO].write;
          state_next.addr = DMA_REQ[DAT_STO].addr;
          state_next.st   = DAT_LOOKUP;
        end
      end
      DAT_LOOKUP:
      begin
        // hit goes straight to the data cycle
        if (hit_m[state_reg.cur])
        begin
          state_next.paddr = {ppage_m[state_reg.cur], cur_ofs};
          state_next.mem   = '{valid: 1'b1, table_fetch: 1'b0, write: state_reg.wr,
                               addr: {ppage_m[state_reg.cur], cur_ofs}};
          state_next.st    = DAT_ISSUE;
        end
        else
        begin
          state_next.mem = '{valid: 1'b1, table_fetch: 1'b1, write: 1'b0,
                             addr: {map_addr, 2'b00}};
          state_next.st  = DAT_FETCH;
        end
      end
      DAT_FETCH:
      begin
        if (MEM_RSP.accept)
        begin
          state_next.mem.valid = 1'b0;
          state_next.st        = DAT_WAIT;
        end
      end
      DAT_WAIT:
      begin
        if (MEM_RSP.rdata_valid)
        begin
          state_next.paddr      = {MEM_RSP.rdata[DAT_PPAGE_W-1:0], cur_ofs};
          state_next.mem        = '{valid: 1'b1, table_fetch: 1'b0, write: state_reg.wr,
                                    addr: {MEM_RSP.rdata[DAT_PPAGE_W-1:0], cur_ofs}};
          state_next.fill       = 1'b1;
          state_next.fill_ppage = MEM_RSP.rdata[DAT_PPAGE_W-1:0];
          state_next.st         = DAT_ISSUE;
        end
      end
      DAT_ISSUE:
      begin
        if (MEM_RSP.accept)
        begin
          state_next.mem.valid            = 1'b0;
          state_next.done[state_reg.cur]  = 1'b1;
          state_next.st                   = DAT_IDLE;
        end
      end
      default:
      begin
        state_next.st = DAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // done held off for one cycle so a master's held request is not taken twice
  assign DMA_DONE  = state_reg.done;
  assign DMA_PADDR = state_reg.paddr;
  assign MEM_REQ   = state_reg.mem;

  sequence s_miss;
    state_reg.st == DAT_LOOKUP && !hit_m[state_reg.cur];
  endsequence

  sequence s_fetch_out;
    MEM_REQ.valid && MEM_REQ.table_fetch;
  endsequence

  property p_tbl_addr;
    @(posedge CLK) disable iff (!ARST_N)
    s_miss |=> s_fetch_out ##0 (MEM_REQ.addr == {MAP_BASE_ADDR[24:17], cur_page, 2'b00});
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("bad table entry address");

  property p_tbl_region;
    @(posedge CLK) disable iff (!ARST_N)
    s_fetch_out |-> MEM_REQ.addr[24:17] == MAP_BASE_ADDR[24:17] && MEM_REQ.addr[1:0] == 2'b00;
  endproperty
  a_tbl_region: assert property (p_tbl_region) else $error("fetch outside table");

  property p_hit_no_fetch;
    @(posedge CLK) disable iff (!ARST_N)
    state_reg.st == DAT_LOOKUP && hit_m[state_reg.cur]
      |=> MEM_REQ.valid && !MEM_REQ.table_fetch && state_reg.st == DAT_ISSUE;
  endproperty
  a_hit_no_fetch: assert property (p_hit_no_fetch) else $error("hit caused table fetch");

  property p_join;
    @(posedge CLK) disable iff (!ARST_N)
    state_reg.st == DAT_WAIT && MEM_RSP.rdata_valid
      |=> DMA_PADDR == {$past(MEM_RSP.rdata[15:0]), cur_ofs} && state_reg.fill;
  endproperty
  a_join: assert property (p_join) else $error("physical address not joined");

  property p_prio;
    @(posedge CLK) disable iff (!ARST_N)
    state_reg.st == DAT_IDLE && want[DAT_NET] && want[DAT_STO]
      |=> state_reg.cur == 1'b0 && state_reg.st == DAT_LOOKUP;
  endproperty
  a_prio: assert property (p_prio) else $error("storage won over network");

  property p_ofs;
    @(posedge CLK) disable iff (!ARST_N)
    MEM_REQ.valid && !MEM_REQ.table_fetch |-> MEM_REQ.addr[8:0] == cur_ofs
      && MEM_REQ.write == state_reg.wr;
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset not carried");

  // page and direction still stand the cycle after a refill, so the entry must hit
  property p_refill_hit;
    @(posedge CLK) disable iff (!ARST_N)
    state_reg.fill |=> hit_m[state_reg.cur];
  endproperty
  a_refill_hit: assert property (p_refill_hit) else $error("refilled entry missed");

  property p_done;
    @(posedge CLK) disable iff (!ARST_N)
    state_reg.st == DAT_ISSUE && MEM_RSP.accept |=> DMA_DONE[state_reg.cur] ##1 DMA_DONE == '0;
  endproperty
  a_done: assert property (p_done) else $error("done not a single pulse");

endmodule : dat_translator

//--- verilog/dat_pkg.sv
// dat_pkg: shared constants and carrier types of the dma address translator
package dat_pkg;

  localparam int DAT_MASTERS    = 2;
  localparam int DAT_NET        = 0;
  localparam int DAT_STO        = 1;
  localparam int DAT_ADDR_W     = 24;
  localparam int DAT_PAGE_W     = 15;
  localparam int DAT_OFS_W      = 9;
  localparam int DAT_PPAGE_W    = 16;
  localparam int DAT_PHYS_W     = 25;
  localparam int DAT_DATA_W     = 32;
  localparam int DAT_TBL_ENTRY  = 32768;
  localparam int DAT_BASE_HI    = 24;
  localparam int DAT_BASE_LO    = 17;
  localparam int DAT_MAP_ADDR_W = 23;
  localparam int DAT_ENTRY_RST  = 0;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [DAT_ADDR_W-1:0]   addr;
  } dat_dma_req_s;

  typedef struct packed {
    logic                    valid;
    logic                    table_fetch;
    logic                    write;
    logic [DAT_PHYS_W-1:0]   addr;
  } dat_mem_req_s;

  typedef struct packed {
    logic                    accept;
    logic                    rdata_valid;
    logic [DAT_DATA_W-1:0]   rdata;
  } dat_mem_rsp_s;

  typedef struct packed {
    logic                    valid;
    logic [DAT_PAGE_W-1:0]   tag;
    logic [DAT_PPAGE_W-1:0]  ppage;
  } dat_entry_s;

  typedef enum logic [2:0] {
    DAT_IDLE   = 3'b000,
    DAT_LOOKUP = 3'b001,
    DAT_FETCH  = 3'b010,
    DAT_WAIT   = 3'b011,
    DAT_ISSUE  = 3'b100
  } dat_state_e;

endpackage : dat_pkg

//--- verilog/dat_cache.sv
// dat_cache: per-master read and write translation entries
module dat_cache
  import dat_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // lookup
  input  wire logic                        lk_write,
  input  wire logic [dat_pkg::DAT_PAGE_W-1:0]  lk_page,
  output logic                             hit,
  output logic [dat_pkg::DAT_PPAGE_W-1:0]  hit_ppage,
  // refill
  input  wire logic                        fill,
  input  wire logic                        fill_write,
  input  wire logic [dat_pkg::DAT_PAGE_W-1:0]  fill_page,
  input  wire logic [dat_pkg::DAT_PPAGE_W-1:0] fill_ppage
);
  import dat_pkg::*;

  typedef struct packed {
    dat_entry_s rd;
    dat_entry_s wr;
    logic       seen;
  } dat_cache_s;

  dat_cache_s state_reg;
  dat_cache_s state_next;
  dat_entry_s sel;

  always_comb
  begin
    sel       = lk_write ? state_reg.wr : state_reg.rd;
    hit       = sel.valid && (sel.tag == lk_page);
    hit_ppage = sel.ppage;
  end

  always_comb
  begin
    state_next = state_reg;
    if (fill)
    begin
      state_next.seen = 1'b1;
      if (fill_write)
      begin
        state_next.wr = '{valid: 1'b1, tag: fill_page, ppage: fill_ppage};
      end
      else
      begin
        state_next.rd = '{valid: 1'b1, tag: fill_page, ppage: fill_ppage};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  property p_fill_hits;
    @(posedge clk) disable iff (!arst_n)
    fill |=> ($past(fill_write) ? state_reg.wr.tag : state_reg.rd.tag) == $past(fill_page)
      && ($past(fill_write) ? state_reg.wr.valid : state_reg.rd.valid);
  endproperty
  a_fill_hits: assert property (p_fill_hits) else $error("refill not stored");

  property p_no_hit_before_fill;
    @(posedge clk) disable iff (!arst_n)
    hit |-> state_reg.seen;
  endproperty
  a_no_hit_before_fill: assert property (p_no_hit_before_fill) else $error("hit before refill");

  property p_stable;
    @(posedge clk) disable iff (!arst_n)
    !fill |=> $stable(state_reg);
  endproperty
  a_stable: assert property (p_stable) else $error("cache changed without refill");

endmodule : dat_cache

//--- tb/dat_mem_model.sv
// main memory model answering translator requests
module dat_mem_model
  import dat_pkg::*;
(
  // clock
  input  wire logic         CLK,
  // memory port
  input  dat_pkg::dat_mem_req_s MEM_REQ,
  output dat_pkg::dat_mem_rsp_s MEM_RSP
);
  timeunit 1ns;
  timeprecision 1ns;
  dat_mem_req_s req;
  initial
  begin
    MEM_RSP = '0;
    forever
    begin
      @(negedge CLK);
      if (MEM_REQ.valid === 1'b1)
      begin
        req = MEM_REQ;
        repeat ($urandom_range(3)) @(posedge CLK);
        @(posedge CLK) #1 MEM_RSP.accept = 1'b1;
        @(posedge CLK) #1 MEM_RSP.accept = 1'b0;
        if (req.table_fetch)
        begin
          repeat ($urandom_range(3)) @(posedge CLK);
          // upper half is junk, so a translator using it gets caught
          @(posedge CLK) #1 MEM_RSP = '{1'b0, 1'b1, {16'($urandom), req.addr[17:2] ^ 16'h5a5a}};
          // a released bus shows the inverse, never the last word
          @(posedge CLK) #1 MEM_RSP = '{1'b0, 1'b0, ~MEM_RSP.rdata};
        end
      end
    end
  end
endmodule : dat_mem_model

//--- tb/dat_translator_bench.sv
// self-checking bench of the dma address translator
module dat_translator_bench
  import dat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                           CLK;
  logic                           ARST_N;
  logic [DAT_PHYS_W-1:0]          MAP_BASE_ADDR;
  dat_dma_req_s [DAT_MASTERS-1:0] DMA_REQ;
  logic [DAT_MASTERS-1:0]         DMA_DONE;
  logic [DAT_PHYS_W-1:0]          DMA_PADDR;
  dat_mem_req_s                   MEM_REQ;
  dat_mem_rsp_s                   MEM_RSP;
  dat_mem_req_s                   notes[$];
  dat_mem_req_s                   exp;
  logic [DAT_PAGE_W-1:0]          tag_m[2][2];
  logic                           vld_m[2][2];
  int                             n_mismatch;
  int                             comparisons;
  int                             seed;
  logic [DAT_ADDR_W-1:0]          a_net;
  logic [DAT_ADDR_W-1:0]          a_sto;
  logic                           w_sto;

  dat_translator uut (.CLK(CLK), .ARST_N(ARST_N), .MAP_BASE_ADDR(MAP_BASE_ADDR),
    .DMA_REQ(DMA_REQ), .DMA_DONE(DMA_DONE), .DMA_PADDR(DMA_PADDR),
    .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP));
  dat_mem_model partner (.CLK(CLK), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP));

  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic bad(input string msg);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : bad

  task automatic chk_req(input dat_mem_req_s e);
    comparisons++;
    if (MEM_REQ !== e) bad($sformatf("memory request %h, want %h", MEM_REQ, e));
  endtask : chk_req

  task automatic chk_paddr(input logic [DAT_PHYS_W-1:0] e);
    comparisons++;
    if (DMA_PADDR !== e) bad($sformatf("physical address %h, want %h", DMA_PADDR, e));
  endtask : chk_paddr

  task automatic chk_done(input logic [DAT_MASTERS-1:0] e);
    comparisons++;
    if (DMA_DONE !== e) bad($sformatf("done %b, want %b", DMA_DONE, e));
  endtask : chk_done

  always @(negedge CLK)
  begin
    if (MEM_REQ.valid === 1'b1 && MEM_RSP.accept === 1'b1)
    begin
      if (notes.size() == 0)
        bad("memory request not expected");
      else
      begin
        exp = notes.pop_front();
        chk_req(exp);
        if (!exp.table_fetch)
          chk_paddr(exp.addr);
      end
    end
  end

  task automatic wrap_up();
    if (notes.size() != 0)
      bad("expected memory requests never came");
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // cache model decides fetch or hit
  task automatic plan(input int m, input logic w, input logic [DAT_ADDR_W-1:0] a);
    logic [DAT_PAGE_W-1:0] pg;
    pg = a[23:9];
    if (!(vld_m[m][w] && tag_m[m][w] == pg))
      notes.push_back('{1'b1, 1'b1, 1'b0, {MAP_BASE_ADDR[24:17], pg, 2'b00}});
    vld_m[m][w] = 1'b1;
    tag_m[m][w] = pg;
    notes.push_back('{1'b1, 1'b0, w, {{MAP_BASE_ADDR[17], pg} ^ 16'h5a5a, a[8:0]}});
  endtask : plan

  task automatic dma(input int m, input logic w, input logic [DAT_ADDR_W-1:0] a);
    int i;
    @(posedge CLK) #1 DMA_REQ[m] = '{1'b1, w, a};
    for (i = 0; i < 300; i++)
    begin
      @(negedge CLK);
      if (DMA_DONE[m] === 1'b1)
        break;
    end
    if (i == 300)
    begin
      bad("dma cycle never completed");
      wrap_up();
    end
    chk_done(2'(1 << m));
    // a released request shows junk, not its last address
    @(posedge CLK) #1 DMA_REQ[m] = '{1'b0, ~w, ~a};
    @(negedge CLK);
    chk_done('0);
  endtask : dma

  task automatic one(input int m, input logic w, input logic [DAT_ADDR_W-1:0] a);
    plan(m, w, a);
    dma(m, w, a);
  endtask : one

  task automatic do_reset();
    @(posedge CLK) #1 ARST_N = 1'b0;
    MAP_BASE_ADDR = 25'($urandom);
    foreach (vld_m[i, j])
      vld_m[i][j] = 1'b0;
    repeat (12) @(posedge CLK);
    #1 ARST_N = 1'b1;
    // reset values still stand before the first edge after release
    @(negedge CLK);
    chk_req('0);
    chk_paddr('0);
    chk_done('0);
  endtask : do_reset

  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    seed = $urandom(11618);
    ARST_N = 1'b0;
    DMA_REQ = '0;
    do_reset();
    one(DAT_NET, 1'b0, 24'h012345);
    one(DAT_NET, 1'b0, 24'h0123ff);
    one(DAT_NET, 1'b1, 24'h012300);
    one(DAT_NET, 1'b0, 24'h012301);
    one(DAT_STO, 1'b0, 24'h012345);
    one(DAT_STO, 1'b1, 24'hffffff);
    one(DAT_STO, 1'b1, 24'h000000);
    do_reset();
    one(DAT_NET, 1'b0, 24'h012345);
    one(DAT_STO, 1'b1, 24'h000000);
    // both masters request on one edge
    repeat (6)
    begin
      a_net = {13'h0a5a, 2'($urandom_range(2)), 9'($urandom)};
      a_sto = {13'h0a5a, 2'($urandom_range(2)), 9'($urandom)};
      w_sto = 1'($urandom);
      // network is served first, so its notes go first
      plan(DAT_NET, 1'b0, a_net);
      plan(DAT_STO, w_sto, a_sto);
      fork
        dma(DAT_NET, 1'b0, a_net);
        dma(DAT_STO, w_sto, a_sto);
      join
    end
    wrap_up();
  end
endmodule : dat_translator_bench
